// ===== hw/pca_regs.svh
`ifndef CCA_REGS_SVH
`define CCA_REGS_SVH

// Register map, one byte per address.
`define ADDR_CTRL       8'h00
`define ADDR_CNT_L      8'h01
`define ADDR_CNT_H      8'h02
`define ADDR_IRQ_STAT   8'h03
`define ADDR_IRQ_MASK   8'h04
`define ADDR_GUARD_KICK 8'h05
`define ADDR_CCM_BASE   8'h10
`define CCM_OFS_CFG     2'h0
`define CCM_OFS_CMP_L   2'h1
`define CCM_OFS_CMP_H   2'h2

// Control register fields.
`define CTRL_SEL_LSB 0
`define CTRL_SEL_MSB 2
`define CTRL_RUN_BIT 3

// Status and mask layout: bits 4..0 module events, bit 5 counter wrap.
`define STAT_WRAP_BIT 5

// Reset values.
`define CTRL_RST      8'h00
`define CFG_RST       8'h00
`define GUARD_CFG_RST 8'h07
`define CMP_RST       16'h0000
`define GUARD_CMP_RST 16'hFF00

// Prescaler divisors.
`define DIV_SYS_SLOW 12
`define DIV_SYS_FAST 4
`define DIV_EXT_OSC  8
`endif

// ===== hw/pca_pkg.sv
`default_nettype none
package cca_pkg;

   typedef enum logic [2:0] {
      SRC_SYS_DIV12,
      SRC_SYS_DIV4,
      SRC_TIMER0,
      SRC_EXT_COUNT,
      SRC_SYS,
      SRC_EXT_OSC_DIV8
   } clk_src_t;

   typedef enum logic [2:0] {
      MODE_OFF,
      MODE_CAPTURE,
      MODE_SW_TIMER,
      MODE_HS_OUTPUT,
      MODE_PWM8,
      MODE_PWM16,
      MODE_FREQ_OUT,
      MODE_GUARD
   } mode_t;

   typedef struct packed {
      logic [2:0] spare;
      logic       cap_fall;
      logic       cap_rise;
      mode_t      mode;
   } ccm_cfg_t;

endpackage
`default_nettype wire

// ===== hw/tick_div.sv
`timescale 1ns/10ps
`default_nettype none
module tick_div #(
   parameter int DIV = 4
) (
   // Clock and reset
   input  wire logic i_clk,
   input  wire logic i_sys_rst,
   // Count enable and tick out
   input  wire logic i_en,
   output logic      o_tick
);
   localparam int CW = $clog2(DIV);
   localparam logic [CW-1:0] LAST = CW'(DIV - 1);

   logic [CW-1:0] cnt_r;

   assign o_tick = i_en && (cnt_r == LAST);

   always_ff @(posedge i_clk) begin
      if (i_sys_rst || o_tick) begin
         cnt_r <= '0;
      end else if (i_en) begin
         cnt_r <= cnt_r + CW'(1);
      end
   end
endmodule // tick_div
`default_nettype wire

// ===== hw/edge_detect.sv
`timescale 1ns/10ps
`default_nettype none
module edge_detect (
   // Clock and reset
   input  wire logic i_clk,
   input  wire logic i_sys_rst,
   // Level in, edge pulses out
   input  wire logic i_level,
   output logic      o_rise,
   output logic      o_fall
);
   logic prev_r;

   assign o_rise = i_level && !prev_r;
   assign o_fall = !i_level && prev_r;

   always_ff @(posedge i_clk) begin
      // Tracking the pin during reset keeps a pin that idles high from
      // showing a false edge right after release.
      if (i_sys_rst) begin
         prev_r <= i_level;
      end else begin
         prev_r <= i_level;
      end
   end
endmodule // edge_detect
`default_nettype wire

// ===== hw/programmable_counter_array.sv
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "pca_regs.svh"
module programmable_counter_array
   import cca_pkg::*;
#(
   parameter int NUM_CCM   = 5,
   parameter int GUARD_IDX = 4
) (
   // Clock and reset
   input  wire logic               i_clk,
   input  wire logic               i_sys_rst,
   // Register port
   input  wire logic [7:0]         i_addr,
   input  wire logic [7:0]         i_wr_data,
   input  wire logic               i_wr_stb,
   input  wire logic               i_rd_stb,
   output logic      [7:0]         o_rd_data,
   // Debug halt from the core
   input  wire logic               i_dbg_halt,
   // Time-base clock sources
   input  wire logic               i_timer0_ovf,
   input  wire logic               i_ext_count_in,
   input  wire logic               i_ext_osc,
   // Crossbar-facing module I/O
   input  wire logic [NUM_CCM-1:0] i_ccm_in,
   output logic      [NUM_CCM-1:0] o_ccm_out,
   output logic      [NUM_CCM-1:0] o_ccm_oe,
   // Interrupt and guard timeout
   output logic                    o_irq,
   output logic                    o_guard_timeout
);
   localparam int SW = NUM_CCM + 1;
   localparam int IW = $clog2(NUM_CCM);

   // Register state.
   logic [7:0]         ctrl_r;
   logic [15:0]        cnt_r;
   logic [15:0]        cnt_nxt;
   logic [SW-1:0]      stat_r;
   logic [SW-1:0]      stat_nxt;
   logic [SW-1:0]      mask_r;
   logic [7:0]         cfg_r [NUM_CCM];
   logic [15:0]        cmp_r [NUM_CCM];
   logic [15:0]        cmp_nxt [NUM_CCM];
   logic [NUM_CCM-1:0] out_r;
   logic [NUM_CCM-1:0] out_nxt;
   logic [NUM_CCM-1:0] oe_r;
   logic [NUM_CCM-1:0] oe_nxt;
   logic [NUM_CCM-1:0] evt;
   logic [NUM_CCM-1:0] match;
   logic [7:0]         rd_r;
   logic               irq_r;
   logic               timeout_r;

   // Address decode.
   wire logic [7:0]    ccm_rel  = i_addr - `ADDR_CCM_BASE;
   wire logic          ccm_hit  = (i_addr >= `ADDR_CCM_BASE)
                                  && (int'(ccm_rel[7:2]) < NUM_CCM);
   wire logic [IW-1:0] ccm_idx  = ccm_rel[IW+1:2];
   wire logic [1:0]    ccm_ofs  = ccm_rel[1:0];
   wire logic          ccm_wr   = i_wr_stb && ccm_hit;
   wire logic          wr_ctrl  = i_wr_stb && (i_addr == `ADDR_CTRL);
   wire logic          wr_cnt_l = i_wr_stb && (i_addr == `ADDR_CNT_L);
   wire logic          wr_cnt_h = i_wr_stb && (i_addr == `ADDR_CNT_H);
   wire logic          wr_stat  = i_wr_stb && (i_addr == `ADDR_IRQ_STAT);
   wire logic          wr_mask  = i_wr_stb && (i_addr == `ADDR_IRQ_MASK);
   wire logic          wr_kick  = i_wr_stb && (i_addr == `ADDR_GUARD_KICK);

   // Guard state.
   wire ccm_cfg_t guard_cfg = ccm_cfg_t'(cfg_r[GUARD_IDX]);
   wire logic     guard_on  = (guard_cfg.mode == MODE_GUARD);

   // Time-base clock selection. Every prescaler freezes under debug halt so the
   // phase of the divided clocks is kept across a breakpoint.
   wire logic     run_en   = ctrl_r[`CTRL_RUN_BIT] || guard_on;
   wire logic     live     = run_en && !i_dbg_halt;
   wire clk_src_t src_sel  = clk_src_t'(ctrl_r[`CTRL_SEL_MSB:`CTRL_SEL_LSB]);
   logic          tick_div12;
   logic          tick_div4;
   logic          tick_osc8;
   logic          ext_cnt_rise;
   logic          ext_osc_rise;

   tick_div #(
      .DIV (`DIV_SYS_SLOW)
   ) u_div12 (
      .i_clk     (i_clk),
      .i_sys_rst (i_sys_rst),
      .i_en      (live),
      .o_tick    (tick_div12)
   );

   tick_div #(
      .DIV (`DIV_SYS_FAST)
   ) u_div4 (
      .i_clk     (i_clk),
      .i_sys_rst (i_sys_rst),
      .i_en      (live),
      .o_tick    (tick_div4)
   );

   // The oscillator input is sampled on the system clock, so it must run below
   // half the system rate to be counted faithfully.
   edge_detect u_osc_edge (
      .i_clk     (i_clk),
      .i_sys_rst (i_sys_rst),
      .i_level   (i_ext_osc),
      .o_rise    (ext_osc_rise),
      .o_fall    ()
   );

   tick_div #(
      .DIV (`DIV_EXT_OSC)
   ) u_osc8 (
      .i_clk     (i_clk),
      .i_sys_rst (i_sys_rst),
      .i_en      (live && ext_osc_rise),
      .o_tick    (tick_osc8)
   );

   edge_detect u_cnt_edge (
      .i_clk     (i_clk),
      .i_sys_rst (i_sys_rst),
      .i_level   (i_ext_count_in),
      .o_rise    (ext_cnt_rise),
      .o_fall    ()
   );

   wire logic src_tick =
      (src_sel == SRC_SYS_DIV12)    ? tick_div12   :
      (src_sel == SRC_SYS_DIV4)     ? tick_div4    :
      (src_sel == SRC_TIMER0)       ? i_timer0_ovf :
      (src_sel == SRC_EXT_COUNT)    ? ext_cnt_rise :
      (src_sel == SRC_SYS)          ? 1'b1         :
      (src_sel == SRC_EXT_OSC_DIV8) ? tick_osc8    : 1'b0;

   wire logic tick = live && src_tick;

   // Time base: one step per tick, natural 16-bit wrap, software may load it.
   wire logic [15:0] cnt_inc = cnt_r + 16'h0001;
   wire logic        wrap    = tick && (cnt_r == 16'hFFFF);

   always_comb begin
      cnt_nxt = tick ? cnt_inc : cnt_r;
      if (wr_cnt_l) begin
         cnt_nxt[7:0] = i_wr_data;
      end
      if (wr_cnt_h) begin
         cnt_nxt[15:8] = i_wr_data;
      end
   end

   // Capture/compare modules.
   for (genvar n = 0; n < NUM_CCM; n++) begin : g_ccm
      ccm_cfg_t   cfg;
      logic       in_rise;
      logic       in_fall;
      logic       cap_hit;
      logic       wr_me;
      logic       is_guard;

      assign cfg      = ccm_cfg_t'(cfg_r[n]);
      assign wr_me    = ccm_wr && (ccm_idx == IW'(n));
      assign is_guard = (n == GUARD_IDX);
      assign match[n] = tick && (cnt_r == cmp_r[n]);
      assign cap_hit  = !i_dbg_halt
                        && ((cfg.cap_rise && in_rise) || (cfg.cap_fall && in_fall));

      edge_detect u_in_edge (
         .i_clk     (i_clk),
         .i_sys_rst (i_sys_rst),
         .i_level   (i_ccm_in[n]),
         .o_rise    (in_rise),
         .o_fall    (in_fall)
      );

      always_comb begin
         cmp_nxt[n] = cmp_r[n];
         out_nxt[n] = out_r[n];
         oe_nxt[n]  = 1'b0;
         evt[n]     = 1'b0;
         case (cfg.mode)
            MODE_CAPTURE: begin
               if (cap_hit) begin
                  cmp_nxt[n] = cnt_r;
                  evt[n]     = 1'b1;
               end
            end
            MODE_SW_TIMER: begin
               evt[n] = match[n];
            end
            MODE_HS_OUTPUT: begin
               oe_nxt[n] = 1'b1;
               if (match[n]) begin
                  out_nxt[n] = !out_r[n];
                  evt[n]     = 1'b1;
               end
            end
            MODE_PWM8: begin
               oe_nxt[n] = 1'b1;
               if (tick) begin
                  out_nxt[n] = (cnt_inc[7:0] < cmp_r[n][15:8]);
               end
               evt[n] = tick && (cnt_r[7:0] == 8'hFF);
            end
            MODE_PWM16: begin
               oe_nxt[n] = 1'b1;
               if (tick) begin
                  out_nxt[n] = (cnt_inc < cmp_r[n]);
               end
               evt[n] = wrap;
            end
            MODE_FREQ_OUT: begin
               // Low byte is the next toggle point, high byte the half period.
               oe_nxt[n] = 1'b1;
               if (tick && (cnt_r[7:0] == cmp_r[n][7:0])) begin
                  out_nxt[n]       = !out_r[n];
                  cmp_nxt[n][7:0]  = cmp_r[n][7:0] + cmp_r[n][15:8];
               end
            end
            default: begin
            end
         endcase
         if (wr_me && (ccm_ofs == `CCM_OFS_CMP_L)) begin
            cmp_nxt[n][7:0] = i_wr_data;
         end
         if (wr_me && (ccm_ofs == `CCM_OFS_CMP_H)) begin
            cmp_nxt[n][15:8] = i_wr_data;
         end
         // A kick pushes the deadline one window past the present count.
         if (is_guard && guard_on && wr_kick) begin
            cmp_nxt[n] = cnt_r + {i_wr_data, 8'h00};
         end
      end

      always_ff @(posedge i_clk) begin
         if (i_sys_rst) begin
            cfg_r[n] <= is_guard ? `GUARD_CFG_RST : `CFG_RST;
            cmp_r[n] <= is_guard ? `GUARD_CMP_RST : `CMP_RST;
            out_r[n] <= 1'b0;
            oe_r[n]  <= 1'b0;
         end else begin
            if (wr_me && (ccm_ofs == `CCM_OFS_CFG)) begin
               cfg_r[n] <= i_wr_data;
            end
            cmp_r[n] <= cmp_nxt[n];
            out_r[n] <= out_nxt[n];
            oe_r[n]  <= oe_nxt[n];
         end
      end
   end

   // Interrupt status: a fresh event wins over a write-one-to-clear.
   wire logic [SW-1:0] stat_set = {wrap, evt};
   wire logic [SW-1:0] stat_clr = wr_stat ? i_wr_data[SW-1:0] : '0;

   assign stat_nxt = (stat_r & ~stat_clr) | stat_set;

   // Read mux.
   wire logic [7:0] ccm_rd =
      (ccm_ofs == `CCM_OFS_CFG)   ? cfg_r[ccm_idx]        :
      (ccm_ofs == `CCM_OFS_CMP_L) ? cmp_r[ccm_idx][7:0]   :
      (ccm_ofs == `CCM_OFS_CMP_H) ? cmp_r[ccm_idx][15:8]  : 8'h00;

   wire logic [7:0] rd_mux =
      ccm_hit                         ? ccm_rd                    :
      (i_addr == `ADDR_CTRL)          ? ctrl_r                    :
      (i_addr == `ADDR_CNT_L)         ? cnt_r[7:0]                :
      (i_addr == `ADDR_CNT_H)         ? cnt_r[15:8]               :
      (i_addr == `ADDR_IRQ_STAT)      ? 8'(stat_r)                :
      (i_addr == `ADDR_IRQ_MASK)      ? 8'(mask_r)                :
      (i_addr == `ADDR_GUARD_KICK)    ? {7'h00, timeout_r}        : 8'h00;

   // Guard timeout is sticky until the system reset it requests.
   wire logic guard_fire = guard_on && match[GUARD_IDX];

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         ctrl_r    <= `CTRL_RST;
         cnt_r     <= 16'h0000;
         stat_r    <= '0;
         mask_r    <= '0;
         rd_r      <= 8'h00;
         irq_r     <= 1'b0;
         timeout_r <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            ctrl_r <= i_wr_data;
         end
         if (wr_mask) begin
            mask_r <= i_wr_data[SW-1:0];
         end
         cnt_r     <= cnt_nxt;
         stat_r    <= stat_nxt;
         rd_r      <= i_rd_stb ? rd_mux : 8'h00;
         irq_r     <= |(stat_nxt & (wr_mask ? i_wr_data[SW-1:0] : mask_r));
         timeout_r <= timeout_r || guard_fire;
      end
   end

   assign o_rd_data       = rd_r;
   assign o_ccm_out       = out_r;
   assign o_ccm_oe        = oe_r;
   assign o_irq           = irq_r;
   assign o_guard_timeout = timeout_r;

endmodule // programmable_counter_array
`default_nettype wire

// ===== sim/counter_array_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module counter_array_assertions #(
   parameter int NUM_CCM = 5
) (
   // Clock, reset, register port and debug halt
   input wire logic               i_clk,
   input wire logic               i_sys_rst,
   input wire logic               i_wr_stb,
   input wire logic               i_rd_stb,
   input wire logic [7:0]         o_rd_data,
   input wire logic               i_dbg_halt,
   // Pins and flags
   input wire logic [NUM_CCM-1:0] o_ccm_out,
   input wire logic [NUM_CCM-1:0] o_ccm_oe,
   input wire logic               o_irq,
   input wire logic               o_guard_timeout
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_sys_rst);

   chk_rd_quiet: assert property (
      !$past(i_rd_stb) |-> o_rd_data == 8'h00) else $error("read data outside read slot");
   chk_reset_idle: assert property (
      $fell(i_sys_rst) |-> !o_irq && !o_guard_timeout && o_ccm_oe == '0)
      else $error("outputs not idle after reset");
   chk_guard_sticky: assert property (
      o_guard_timeout |=> o_guard_timeout) else $error("guard timeout dropped");
   chk_guard_halted: assert property (
      $rose(o_guard_timeout) |-> !$past(i_dbg_halt)) else $error("guard fired while halted");
   chk_out_frozen: assert property (
      $changed(o_ccm_out) |-> !$past(i_dbg_halt)) else $error("module output moved while halted");
   chk_oe_by_write: assert property (
      $changed(o_ccm_oe) |-> $past(i_wr_stb) || $past(i_wr_stb, 2))
      else $error("pin enable changed without a write");
   chk_irq_rise: assert property (
      $rose(o_irq) |-> !$past(i_dbg_halt) || $past(i_wr_stb)) else $error("interrupt rose while halted");
   chk_irq_fall: assert property (
      $fell(o_irq) |-> $past(i_wr_stb) || $past(i_wr_stb, 2)) else $error("interrupt fell by itself");
endmodule // counter_array_assertions

bind programmable_counter_array counter_array_assertions #(.NUM_CCM(NUM_CCM)) u_chk (
   .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_wr_stb(i_wr_stb), .i_rd_stb(i_rd_stb),
   .o_rd_data(o_rd_data), .i_dbg_halt(i_dbg_halt), .o_ccm_out(o_ccm_out),
   .o_ccm_oe(o_ccm_oe), .o_irq(o_irq), .o_guard_timeout(o_guard_timeout)
);
`default_nettype wire

// ===== sim/pin_partner.sv
`timescale 1ns/10ps
`default_nettype none
module pin_partner (
   // Clock and oscillator enable
   input  wire logic i_clk,
   input  wire logic i_osc_en,
   // Pin levels
   output logic       o_ext_osc,
   output logic       o_ext_count,
   output logic [4:0] o_pin_drive
);
   logic [1:0] ph;

   initial begin
      ph = 2'h0;
      o_ext_osc = 1'b0;
      o_ext_count = 1'b0;
      o_pin_drive = 5'h00;
   end

   // A quarter of the system rate keeps the oscillator well below its limit.
   always @(posedge i_clk) begin
      if (i_osc_en) begin
         ph <= ph + 2'h1;
         o_ext_osc <= ph[1];
      end
   end

   task automatic count_pulses(input int n);
      repeat (n) begin
         @(posedge i_clk);
         o_ext_count <= 1'b1;
         repeat (2) @(posedge i_clk);
         o_ext_count <= 1'b0;
         repeat (2) @(posedge i_clk);
      end
   endtask

   task automatic set_pin(input int idx, input logic v);
      @(posedge i_clk);
      o_pin_drive[idx] <= v;
   endtask
endmodule // pin_partner
`default_nettype wire

// ===== sim/counter_array_capture_compare_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "pca_regs.svh"
module counter_array_capture_compare_tb;
   logic       clk, rst, wr, rd, halt, t0, osc_en, ext_osc, ext_cnt, irq, tmo;
   logic [7:0] addr, wdata, rdata;
   logic [4:0] ccm_in, ccm_out, ccm_oe, pin;
   int         err_total, n_checks;

   // The pin level is the module's own drive wherever it is enabled.
   assign ccm_in = (ccm_oe & ccm_out) | (~ccm_oe & pin);

   programmable_counter_array dut (
      .i_clk(clk), .i_sys_rst(rst), .i_addr(addr), .i_wr_data(wdata), .i_wr_stb(wr),
      .i_rd_stb(rd), .o_rd_data(rdata), .i_dbg_halt(halt), .i_timer0_ovf(t0),
      .i_ext_count_in(ext_cnt), .i_ext_osc(ext_osc), .i_ccm_in(ccm_in),
      .o_ccm_out(ccm_out), .o_ccm_oe(ccm_oe), .o_irq(irq), .o_guard_timeout(tmo));
   pin_partner pp (.i_clk(clk), .i_osc_en(osc_en), .o_ext_osc(ext_osc),
      .o_ext_count(ext_cnt), .o_pin_drive(pin));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic chk(input logic [15:0] g, e, input int tol);
      logic ok;
      ok = (g + tol >= e) && (g <= e + tol);
      n_checks++;
      if (ok !== 1'b1) begin
         err_total++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wr8(input logic [7:0] a, d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd8(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      d = rdata;
      @(posedge clk);
   endtask
   task automatic rc(input logic [7:0] a, e);
      logic [7:0] v;
      rd8(a, v);
      chk(v, e, 0);
   endtask
   task automatic rdcnt(output logic [15:0] c);
      rd8(`ADDR_CNT_L, c[7:0]);
      rd8(`ADDR_CNT_H, c[15:8]);
   endtask
   task automatic setcnt(input logic [15:0] c);
      wr8(`ADDR_CNT_H, c[15:8]);
      wr8(`ADDR_CNT_L, c[7:0]);
   endtask
   task automatic tick0(input int n);
      repeat (n) begin
         @(posedge clk);
         t0 <= 1'b1;
         @(posedge clk);
         t0 <= 1'b0;
      end
   endtask
   task automatic reset_dut;
      @(posedge clk);
      rst <= 1'b1;
      cyc(12);
      rst <= 1'b0;
   endtask

   task automatic t_reset_guard;
      logic [7:0] ad [7] = '{8'h00, 8'h03, 8'h04, 8'h10, 8'h20, 8'h22, 8'h3F};
      logic [7:0] ex [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h07, 8'hFF, 8'h00};
      logic [15:0] a, b;
      for (int k = 0; k < 7; k++) rc(ad[k], ex[k]);
      rdcnt(a);
      cyc(120);
      rdcnt(b);
      chk(b, a + 16'h000A, 1);
      wr8(8'h20, 8'h00);
      rdcnt(a);
      cyc(50);
      rdcnt(b);
      chk(b, a, 0);
      $display("test reset_guard done");
   endtask

   task automatic t_sources;
      logic [2:0] src [6] = '{3'h0, 3'h1, 3'h4, 3'h2, 3'h3, 3'h5};
      int wt [6] = '{240, 80, 20, 5, 6, 160};
      int ex [6] = '{20, 20, 22, 5, 6, 5};
      int tl [6] = '{1, 1, 1, 0, 0, 1};
      logic [15:0] c;
      for (int k = 0; k < 6; k++) begin
         setcnt(16'h0000);
         wr8(`ADDR_CTRL, {5'h01, src[k]});
         if (src[k] == 3'h2) tick0(wt[k]);
         else if (src[k] == 3'h3) pp.count_pulses(wt[k]);
         else if (src[k] == 3'h5) begin
            osc_en <= 1'b1;
            cyc(wt[k]);
            osc_en <= 1'b0;
            cyc(4);
         end else cyc(wt[k]);
         wr8(`ADDR_CTRL, {5'h00, src[k]});
         rdcnt(c);
         chk(c, ex[k], tl[k]);
      end
      $display("test sources done");
   endtask

   task automatic t_wrap_irq;
      logic [15:0] c;
      setcnt(16'hFFFE);
      wr8(`ADDR_CTRL, 8'h0A);
      tick0(3);
      wr8(`ADDR_CTRL, 8'h02);
      rdcnt(c);
      chk(c, 16'h0001, 0);
      rc(`ADDR_IRQ_STAT, 8'h20);
      chk(irq, 16'h0000, 0);
      wr8(`ADDR_IRQ_MASK, 8'h20);
      cyc(2);
      chk(irq, 16'h0001, 0);
      wr8(`ADDR_IRQ_STAT, 8'h20);
      cyc(2);
      chk(irq, 16'h0000, 0);
      $display("test wrap_irq done");
   endtask

   task automatic t_halt;
      logic [15:0] a, b;
      setcnt(16'h0000);
      wr8(`ADDR_CTRL, 8'h0C);
      halt <= 1'b1;
      rdcnt(a);
      cyc(30);
      rdcnt(b);
      chk(b, a, 0);
      halt <= 1'b0;
      rdcnt(a);
      cyc(30);
      rdcnt(b);
      chk(b, a + 16'h0024, 1);
      wr8(`ADDR_CTRL, 8'h02);
      $display("test halt done");
   endtask

   task automatic t_modes;
      logic o2;
      setcnt(16'h0004);
      wr8(8'h10, 8'h02);
      wr8(8'h11, 8'h05);
      wr8(8'h18, 8'h03);
      wr8(8'h19, 8'h05);
      wr8(8'h1C, 8'h04);
      wr8(8'h1E, 8'h80);
      wr8(8'h14, 8'h09);
      wr8(`ADDR_CTRL, 8'h0A);
      cyc(2);
      chk(ccm_oe[3:0], 16'h000C, 0);
      o2 = ccm_out[2];
      tick0(2);
      cyc(2);
      chk(ccm_out[3:2], {14'h0000, 1'b1, ~o2}, 0);
      rc(`ADDR_IRQ_STAT, 8'h05);
      pp.set_pin(1, 1'b1);
      cyc(3);
      rc(8'h15, 8'h06);
      rc(`ADDR_IRQ_STAT, 8'h07);
      wr8(8'h12, 8'h04);
      wr8(8'h11, 8'h08);
      wr8(8'h10, 8'h06);
      tick0(3);
      cyc(1);
      chk(ccm_out[0], 16'h0001, 0);
      rc(8'h11, 8'h0C);
      $display("test modes done");
   endtask

   task automatic t_guard_timeout;
      int n;
      reset_dut;
      setcnt(16'hFEF0);
      wr8(`ADDR_GUARD_KICK, 8'h01);
      cyc(300);
      chk(tmo, 16'h0000, 0);
      n = 0;
      while (tmo !== 1'b1 && n < 4000) begin
         cyc(1);
         n++;
      end
      chk(tmo, 16'h0001, 0);
      if (tmo !== 1'b1) tally_and_finish;
      rc(`ADDR_GUARD_KICK, 8'h01);
      $display("test guard_timeout done");
   endtask

   task automatic tally_and_finish;
      $display("checks=%0d errors=%0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   initial begin
      {rst, wr, rd, halt, t0, osc_en} = 6'h20;
      addr = 8'h00;
      wdata = 8'h00;
      err_total = 0;
      n_checks = 0;
      reset_dut;
      t_reset_guard;
      t_sources;
      t_wrap_irq;
      t_halt;
      t_modes;
      t_guard_timeout;
      tally_and_finish;
   end
endmodule // counter_array_capture_compare_tb
`default_nettype wire
